// ---- rtl/sfr_regs.vh ----
// Constants of the serial flash read front end
`ifndef SFR_REGS_VH
`define SFR_REGS_VH
// Instruction codes
`define SFR_OP_FAST_READ  8'h0b
`define SFR_OP_DUAL_OUT   8'h3b
`define SFR_OP_DUAL_IO    8'hbb
`define SFR_OP_QUAD_OUT   8'h6b
`define SFR_OP_QUAD_IO    8'heb
`define SFR_OP_ENTER_WIDE 8'hb7
`define SFR_OP_EXIT_WIDE  8'he9
// Configuration bit positions
`define SFR_CFG_WIDE_POS  5
`define SFR_CFG_DSL_POS   6
`define SFR_CFG_DSH_POS   7
// Reset values
`define SFR_WIDE_RST      1'b0
`define SFR_LINES_RST     4'h0
// Line widths as log2 of data lines in use
`define SFR_LG_ONE        2'h0
`define SFR_LG_TWO        2'h1
`define SFR_LG_FOUR       2'h2
// Phase lengths: opcode in serial clocks, address in bits
`define SFR_OPC_CLK_SER   6'h08
`define SFR_OPC_CLK_QUAD  6'h02
`define SFR_ADDR_BITS_3B  6'h18
`define SFR_ADDR_BITS_4B  6'h20
// Dummy clocks per select code
`define SFR_DUMMY_PLAIN   5'h08
`define SFR_DUMMY_DIO_0   5'h04
`define SFR_DUMMY_DIO_1   5'h08
`define SFR_DUMMY_QIO_0   5'h06
`define SFR_DUMMY_QIO_1   5'h04
`define SFR_DUMMY_QIO_2   5'h08
`define SFR_DUMMY_QIO_3   5'h0a
`endif

// ---- rtl/sfr_read_engine.v ----
// Serial flash read command front end: decode, address, dummy and data phases
`timescale 1ns/100ps
`default_nettype none
`include "sfr_regs.vh"

module sfr_read_engine #(
  parameter ADDR_W = 25
) (
  input  wire              clk,
  input  wire              sys_rst,
  input  wire              chipSelectN,
  input  wire              serialClk,
  input  wire [3:0]        dataLinesIn,
  input  wire [7:0]        configBits,
  input  wire              extendedAddressBit,
  input  wire              quadCommandMode,
  input  wire              writeCycleBusy,
  input  wire [7:0]        memData,
  output reg  [3:0]        dataLinesOut,
  output reg  [3:0]        dataLinesOe,
  output reg  [ADDR_W-1:0] memAddr,
  output reg               wideAddressFlag,
  output reg               readActive
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [2:0] ST_OPC   = 3'h0;
  localparam [2:0] ST_ADDR  = 3'h1;
  localparam [2:0] ST_DUMMY = 3'h2;
  localparam [2:0] ST_DATA  = 3'h3;
  localparam [2:0] ST_SKIP  = 3'h4;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Bits taken from the lines on one rising edge
  function [3:0] sampleIn;
    input [1:0] lg;
    input [3:0] io;
    begin
      case (lg)
        `SFR_LG_ONE: sampleIn = {3'h0, io[0]};
        `SFR_LG_TWO: sampleIn = {2'h0, io[1:0]};
        default:     sampleIn = io;
      endcase
    end
  endfunction

  // Top bits of a byte placed on the lines, higher bit on higher line
  function [3:0] laneBits;
    input [1:0] lg;
    input [7:0] b;
    begin
      case (lg)
        `SFR_LG_ONE: laneBits = {2'h0, b[7], 1'b0};
        `SFR_LG_TWO: laneBits = {2'h0, b[7:6]};
        default:     laneBits = b[7:4];
      endcase
    end
  endfunction

  // Lines driven during data out; single data goes out on line one
  function [3:0] laneEnable;
    input [1:0] lg;
    begin
      case (lg)
        `SFR_LG_ONE: laneEnable = 4'h2;
        `SFR_LG_TWO: laneEnable = 4'h3;
        default:     laneEnable = 4'hf;
      endcase
    end
  endfunction

  // Dummy clocks by address width of the read and select code
  function [4:0] dummyClocks;
    input [1:0] lg;
    input [1:0] dc;
    begin
      case (lg)
        `SFR_LG_TWO: dummyClocks = dc[0] ? `SFR_DUMMY_DIO_1 : `SFR_DUMMY_DIO_0;
        `SFR_LG_FOUR: begin
          case (dc)
            2'h0:    dummyClocks = `SFR_DUMMY_QIO_0;
            2'h1:    dummyClocks = `SFR_DUMMY_QIO_1;
            2'h2:    dummyClocks = `SFR_DUMMY_QIO_2;
            default: dummyClocks = `SFR_DUMMY_QIO_3;
          endcase
        end
        default: dummyClocks = `SFR_DUMMY_PLAIN;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // The first stage of each chain never feeds logic, to keep metastability out
  reg  [1:0]        csSync_r;
  reg  [2:0]        clkSync_r;
  reg  [3:0]        ioS1_r;
  reg  [3:0]        ioS2_r;

  // ----------------------------------------
  // Frame state
  // ----------------------------------------
  reg  [2:0]        state_r;
  reg  [5:0]        clkCnt_r;
  reg  [7:0]        opcode_r;
  reg  [31:0]       addr_r;
  reg  [1:0]        addrLog_r;
  reg  [1:0]        dataLog_r;
  reg  [4:0]        dummyLast_r;
  reg               fourByte_r;
  reg  [7:0]        shift_r;
  reg  [2:0]        slotCnt_r;

  // Serial clock edges from the last two stages of its chain
  wire              csHigh   = csSync_r[1];
  wire              sclkRise = clkSync_r[1] & ~clkSync_r[2];
  wire              sclkFall = ~clkSync_r[1] & clkSync_r[2];
  wire [1:0]        dcSel    = {configBits[`SFR_CFG_DSH_POS], configBits[`SFR_CFG_DSL_POS]};

  // Opcode assembly: quad command mode takes a nibble, else line zero only
  wire [7:0]        opcNext  = quadCommandMode ? {opcode_r[3:0], ioS2_r}
                                               : {opcode_r[6:0], ioS2_r[0]};
  wire [5:0]        opcLast  = (quadCommandMode ? `SFR_OPC_CLK_QUAD : `SFR_OPC_CLK_SER) - 6'h01;

  // Address assembly at the width of the current read
  wire [3:0]        addrIn   = sampleIn(addrLog_r, ioS2_r);
  wire [31:0]       addrNext = (addrLog_r == `SFR_LG_ONE) ? {addr_r[30:0], addrIn[0]} :
                               (addrLog_r == `SFR_LG_TWO) ? {addr_r[29:0], addrIn[1:0]} :
                                                            {addr_r[27:0], addrIn};
  wire [5:0]        addrBits = fourByte_r ? `SFR_ADDR_BITS_4B : `SFR_ADDR_BITS_3B;
  wire [5:0]        addrLast = (addrBits >> addrLog_r) - 6'h01;
  wire [31:0]       addrFull = fourByte_r ? addrNext : {8'h00, addrNext[23:0]};
  // Bits moved per falling edge of the data phase
  wire [3:0]        dataStep = 4'h1 << dataLog_r;
  // Wrap is at the array top, so a 3-byte read may stream past 16 MB
  wire [ADDR_W-1:0] addrInc  = (memAddr == {ADDR_W{1'b1}}) ? {ADDR_W{1'b0}}
                                                           : memAddr + 1'b1;

  // ----------------------------------------
  // Instruction decode
  // ----------------------------------------
  reg               decRead;
  reg  [1:0]        decAddrLog;
  reg  [1:0]        decDataLog;

  // Only the quad I/O read is taken in quad command mode
  // Unknown or refused codes park the frame until deselect
  always @* begin
    decRead    = 1'b1;
    decAddrLog = `SFR_LG_ONE;
    decDataLog = `SFR_LG_ONE;
    case (opcNext)
      `SFR_OP_FAST_READ: decRead = ~quadCommandMode;
      `SFR_OP_DUAL_OUT: begin
        decRead    = ~quadCommandMode;
        decDataLog = `SFR_LG_TWO;
      end
      `SFR_OP_DUAL_IO: begin
        decRead    = ~quadCommandMode;
        decAddrLog = `SFR_LG_TWO;
        decDataLog = `SFR_LG_TWO;
      end
      `SFR_OP_QUAD_OUT: begin
        decRead    = ~quadCommandMode;
        decDataLog = `SFR_LG_FOUR;
      end
      `SFR_OP_QUAD_IO: begin
        decAddrLog = `SFR_LG_FOUR;
        decDataLog = `SFR_LG_FOUR;
      end
      default: decRead = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Synchronisers and sequencer
  // ----------------------------------------
  // Everything runs on clk; serial clock edges are found after two stages
  always @(posedge clk) begin
    if (sys_rst) begin
      csSync_r        <= 2'h3;
      clkSync_r       <= 3'h0;
      ioS1_r          <= 4'h0;
      ioS2_r          <= 4'h0;
      state_r         <= ST_OPC;
      clkCnt_r        <= 6'h00;
      opcode_r        <= 8'h00;
      addr_r          <= 32'h0;
      addrLog_r       <= `SFR_LG_ONE;
      dataLog_r       <= `SFR_LG_ONE;
      dummyLast_r     <= 5'h00;
      fourByte_r      <= 1'b0;
      shift_r         <= 8'h00;
      slotCnt_r       <= 3'h0;
      dataLinesOut    <= `SFR_LINES_RST;
      dataLinesOe     <= `SFR_LINES_RST;
      memAddr         <= {ADDR_W{1'b0}};
      wideAddressFlag <= `SFR_WIDE_RST;
      readActive      <= 1'b0;
    end else begin
      csSync_r  <= {csSync_r[0], chipSelectN};
      clkSync_r <= {clkSync_r[1:0], serialClk};
      ioS1_r    <= dataLinesIn;
      ioS2_r    <= ioS1_r;
      if (csHigh) begin
        // Deselect ends any frame and releases the lines at any time
        state_r     <= ST_OPC;
        clkCnt_r    <= 6'h00;
        addr_r      <= 32'h0;
        slotCnt_r   <= 3'h0;
        dataLinesOe <= `SFR_LINES_RST;
        readActive  <= 1'b0;
      end else begin
        if (sclkRise) begin
          case (state_r)
            ST_OPC: begin
              opcode_r <= opcNext;
              clkCnt_r <= clkCnt_r + 6'h01;
              if (clkCnt_r == opcLast) begin
                clkCnt_r <= 6'h00;
                state_r  <= ST_SKIP;
                // Busy is seen only on this last opcode rise; a later start is missed
                if (opcNext == `SFR_OP_ENTER_WIDE) begin
                  wideAddressFlag <= 1'b1;
                end else if (opcNext == `SFR_OP_EXIT_WIDE) begin
                  wideAddressFlag <= 1'b0;
                end else if (decRead && !writeCycleBusy) begin
                  state_r     <= ST_ADDR;
                  readActive  <= 1'b1;
                  addrLog_r   <= decAddrLog;
                  dataLog_r   <= decDataLog;
                  fourByte_r  <= wideAddressFlag | extendedAddressBit;
                  dummyLast_r <= dummyClocks(decAddrLog, dcSel) - 5'h01;
                end
              end
            end
            ST_ADDR: begin
              // Address bits taken on the rising serial edge
              addr_r   <= addrNext;
              clkCnt_r <= clkCnt_r + 6'h01;
              if (clkCnt_r == addrLast) begin
                clkCnt_r <= 6'h00;
                state_r  <= ST_DUMMY;
                // Array address settles long before the first data fall
                memAddr  <= addrFull[ADDR_W-1:0];
              end
            end
            ST_DUMMY: begin
              // Indicator clocks count as dummies; their content is ignored
              clkCnt_r <= clkCnt_r + 6'h01;
              if (clkCnt_r == {1'b0, dummyLast_r}) begin
                clkCnt_r <= 6'h00;
                state_r  <= ST_DATA;
              end
            end
            // Skip and data phases wait for deselect or a falling edge
            default: ;
          endcase
        end
        // Data leaves on the falling serial edge, MSB first
        if (sclkFall && state_r == ST_DATA) begin
          dataLinesOe <= laneEnable(dataLog_r);
          if (slotCnt_r == 3'h0) begin
            dataLinesOut <= laneBits(dataLog_r, memData);
            shift_r      <= memData << dataStep;
            slotCnt_r    <= 3'h7 >> dataLog_r;
            memAddr      <= addrInc;
          end else begin
            dataLinesOut <= laneBits(dataLog_r, shift_r);
            shift_r      <= shift_r << dataStep;
            slotCnt_r    <= slotCnt_r - 3'h1;
          end
        end
      end
    end
  end

endmodule

`default_nettype wire

// ---- tb/sfr_read_properties.sv ----
// Port checks of the flash read front end
`timescale 1ns/100ps
`default_nettype none
module sfr_read_properties #(parameter ADDR_W = 25) (
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic              chipSelectN,
  input wire logic              serialClk,
  input wire logic              writeCycleBusy,
  input wire logic [3:0]        dataLinesOut,
  input wire logic [3:0]        dataLinesOe,
  input wire logic [ADDR_W-1:0] memAddr,
  input wire logic              wideAddressFlag,
  input wire logic              readActive
);
  // One domain; the pin synchronisers explain the 3 to 4 clock slack
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_oe_release: assert property ($rose(chipSelectN) |-> ##[1:4] dataLinesOe == 4'h0) else $error("oe held");
  a_idle_quiet: assert property (chipSelectN && $past(chipSelectN, 4) |-> dataLinesOe == 4'h0 && !readActive)
    else $error("idle drive");
  a_busy_drive: assert property (|dataLinesOe |-> !writeCycleBusy) else $error("drive while busy");
  a_busy_accept: assert property ($rose(readActive) |-> !writeCycleBusy) else $error("accept while busy");
  a_oe_shape: assert property (dataLinesOe inside {4'h0, 4'h2, 4'h3, 4'hf}) else $error("bad oe");
  a_oe_steady: assert property (|dataLinesOe && |$past(dataLinesOe) |-> $stable(dataLinesOe))
    else $error("oe moved");
  a_out_fall: assert property ($changed(dataLinesOut) && |dataLinesOe |-> !serialClk) else $error("late shift");
  a_addr_step: assert property ($changed(memAddr) && |$past(dataLinesOe)
    |-> memAddr == $past(memAddr) + 1'b1) else $error("addr step");
  a_active_first: assert property ($rose(|dataLinesOe) |-> readActive) else $error("oe no read");
  a_wide_frame: assert property ($changed(wideAddressFlag) |-> !chipSelectN && dataLinesOe == 4'h0)
    else $error("wide flag");
endmodule
bind sfr_read_engine sfr_read_properties #(.ADDR_W(ADDR_W)) u_props (.clk(clk), .sys_rst(sys_rst),
  .chipSelectN(chipSelectN), .serialClk(serialClk), .writeCycleBusy(writeCycleBusy),
  .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe), .memAddr(memAddr),
  .wideAddressFlag(wideAddressFlag), .readActive(readActive));
`default_nettype wire

// ---- tb/sfr_host.sv ----
// Host controller model driving read frames
`timescale 1ns/100ps
`default_nettype none
module sfr_host (
  output logic           csN,
  output logic           sck,
  output logic [3:0]     drv,
  input wire logic [3:0] line
);
  logic [7:0] rx [0:7];
  initial begin
    csN = 1;
    sck = 0;
    drv = 0;
  end
  // Mode 0 clock: bits change with the fall, sampled just before the rise
  task automatic clk1(input logic [3:0] d, output logic [3:0] q);
    sck = 0;
    drv = d;
    #40;
    q = line;
    sck = 1;
    #40;
  endtask
  // Serial phases put junk on the unused upper lines
  task automatic snd(input logic [31:0] v, input int n, input int l);
    logic [3:0] q;
    for (int i = n - l; i >= 0; i -= l)
      clk1(4'(v >> i) & 4'((1 << l) - 1) | (l == 1 ? 4'he : 4'h0), q);
  endtask
  // Whole frame; ends in mid data by lifting select
  task automatic frame(input logic [7:0] op, input logic qc, input logic [31:0] a, input int ab, al, dm, dl, nb);
    logic [3:0] q;
    logic [7:0] by;
    csN = 0;
    #40;
    snd(op, 8, qc ? 4 : 1);
    if (ab > 0) snd(a, ab, al);
    if (ab > 0) snd(0, dm * al, al);
    q = 0;
    by = 0;
    for (int b = 0; b < nb; b++)
      for (int j = 0; j < 8 / dl; j++) begin
        clk1(~q, q); // Released lines show the inverse of the last level
        by = (by << dl) | (dl == 1 ? q[1] : q & 4'((1 << dl) - 1));
        rx[b] = by;
      end
    sck = 0;
    #40;
    csN = 1;
    #80;
  endtask
endmodule
`default_nettype wire

// ---- tb/serial_flash_read_commands_bench.sv ----
// Self-checking bench of the flash read front end
`timescale 1ns/100ps
`default_nettype none
`include "sfr_regs.vh"
module serial_flash_read_commands_bench;
  localparam int AW = 25;
  logic          clk = 0, sys_rst = 1, busy = 0, ext = 0, qcm = 0, sawOe = 0, expWide = 0, ok;
  logic [7:0]    cfg = 0, op;
  logic [31:0]   a;
  logic [AW-1:0] ae;
  int            err_count = 0, n_tests = 0, ab, al, dl;
  wire logic [3:0] dOut, dOe, drv, lines;
  wire logic [AW-1:0] memAddr;
  wire logic     csN, sck, wide, act;
  logic [7:0] ops [5] = '{`SFR_OP_FAST_READ, `SFR_OP_DUAL_OUT, `SFR_OP_DUAL_IO, `SFR_OP_QUAD_OUT, `SFR_OP_QUAD_IO};
  // Array contents, a cheap scramble of the address
  function automatic logic [7:0] mf(input logic [AW-1:0] x);
    return x[7:0] ^ x[15:8] ^ {x[24:18], 1'b1};
  endfunction
  function automatic int dumf(input logic [7:0] o, input logic [1:0] dc);
    if (o == `SFR_OP_DUAL_IO) return dc[0] ? 8 : 4;
    if (o == `SFR_OP_QUAD_IO) return dc == 0 ? 6 : dc == 1 ? 4 : dc == 2 ? 8 : 10;
    return 8;
  endfunction
  always #2 clk = ~clk;
  // Wire level from the engine's enables; the host drives every line the engine releases
  assign lines = (dOe & dOut) | (~dOe & drv);
  sfr_read_engine #(.ADDR_W(AW)) DUT (.clk(clk), .sys_rst(sys_rst), .chipSelectN(csN), .serialClk(sck),
    .dataLinesIn(lines), .configBits(cfg), .extendedAddressBit(ext), .quadCommandMode(qcm),
    .writeCycleBusy(busy), .memData(mf(memAddr)), .dataLinesOut(dOut), .dataLinesOe(dOe),
    .memAddr(memAddr), .wideAddressFlag(wide), .readActive(act));
  sfr_host host (.csN(csN), .sck(sck), .drv(drv), .line(lines));
  // Any drive inside a frame marks it accepted
  always @(posedge clk) if (!csN && |dOe) sawOe <= 1;
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog sized well above the thirty frames
  initial begin
    #350000;
    err_count++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'haf3af87c));
    repeat (8) @(posedge clk);
    @(negedge clk) sys_rst = 0;
    repeat (4) @(negedge clk);
    for (int t = 0; t < 30; t++) begin
      if (t % 6 == 5) begin
        op = t % 12 == 5 ? `SFR_OP_ENTER_WIDE : `SFR_OP_EXIT_WIDE;
        busy = 1'($urandom);
        // Opcode framing must follow the current command mode
        host.frame(op, qcm, 0, 0, 0, 0, 0, 0);
        expWide = op == `SFR_OP_ENTER_WIDE;
        chk(wide, expWide, "wide flag");
        continue;
      end
      // Frame 7 is a fixed quad I/O read in quad command mode
      op = t == 7 ? `SFR_OP_QUAD_IO : ops[t < 5 ? t : $urandom % 5];
      cfg = 8'($urandom);
      ext = 1'($urandom);
      qcm = t == 7 || (t > 5 && $urandom % 4 == 0);
      busy = t > 5 && t != 7 && $urandom % 5 == 0;
      a = t % 4 == 1 ? 32'h01fffffe : $urandom; // Top of array forces the wrap with 4-byte addresses
      ab = (ext || expWide) ? 32 : 24;
      ae = ab == 24 ? AW'(a[23:0]) : AW'(a);
      al = op == `SFR_OP_DUAL_IO ? 2 : op == `SFR_OP_QUAD_IO ? 4 : 1;
      dl = op == `SFR_OP_FAST_READ ? 1 : (op == `SFR_OP_DUAL_OUT || op == `SFR_OP_DUAL_IO) ? 2 : 4;
      ok = !busy && (!qcm || op == `SFR_OP_QUAD_IO);
      sawOe = 0;
      host.frame(op, qcm, a, ab, al, dumf(op, cfg[7:6]), dl, 3);
      chk(sawOe, ok, "accept");
      for (int k = 0; k < 3; k++)
        if (ok) chk(host.rx[k], mf(ae + k), "data");
    end
    give_verdict();
  end
endmodule
`default_nettype wire
